// [camera_receiver_pkg.sv]
`default_nettype none
package camera_receiver_pkg;

	// ==========================================================
	// Bus geometry and register offsets (byte addresses)
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RAW_EV = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EV_EN = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MASKED_EV = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EV_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CODES = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CROP_START = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_CROP_SIZE = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h28;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Field layouts and reset values
	localparam logic [31:0] CTRL_WMASK = 32'h0000_4fff;
	localparam logic [31:0] CROP_START_MASK = 32'h1fff_3fff;
	localparam logic [31:0] CROP_SIZE_MASK = 32'h3fff_3fff;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam int EV_LINE = 0;
	localparam int EV_FRAME = 1;
	localparam int EV_OVR = 2;
	localparam int EV_VSYNC = 3;
	localparam int EV_ERR = 4;
	localparam int EV_W = 5;
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_10 = 2'h1;
	localparam logic [1:0] WIDTH_12 = 2'h2;
	localparam logic [1:0] RATE_THIRD = 2'h2;
	localparam logic [1:0] RATE_HALF = 2'h1;
	localparam logic [7:0] SYNC_FF = 8'hff;
	localparam logic [7:0] SYNC_ZERO = 8'h00;
	localparam logic [1:0] CODE_TAIL = 2'h3;
	localparam logic [1:0] LANE_LAST8 = 2'h3;
	localparam logic [1:0] LANE_LAST16 = 2'h1;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 3;

	typedef struct packed {
		logic [16:0] rsv_hi;
		logic enable;
		logic [1:0] rsv_lo;
		logic [1:0] width;
		logic [1:0] rate;
		logic vpol;
		logic hpol;
		logic pedge;
		logic esync;
		logic jpeg;
		logic crop;
		logic snapshot;
		logic capture_enable_bit;
	} ctrl_s;

	typedef struct packed {
		logic [7:0] fe;
		logic [7:0] le;
		logic [7:0] ls;
		logic [7:0] fs;
	} codes_s;

	typedef struct packed {
		logic [13:0] data;
		logic line;
		logic frame;
		logic clk;
	} pins_s;

	typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT, CAP_SKIP, CAP_ACTIVE} cap_state_e;

endpackage : camera_receiver_pkg
`default_nettype wire

// [camera_receiver.sv]
`timescale 1ns/1ps
`default_nettype none
module camera_receiver (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [camera_receiver_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [camera_receiver_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pixel_clock_in,
	input wire logic [13:0] pixel_data_in,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	output logic dma_req,
	output logic global_capture_irq
);
	import camera_receiver_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [15:0] wide_sample(input logic [13:0] d, input logic [1:0] w);
		logic [15:0] r;
		r = {2'h0, d};
		unique case (w)
			WIDTH_10: r[15:10] = 6'h00;
			WIDTH_12: r[15:12] = 4'h0;
			default: r = r;
		endcase
		return r;
	endfunction : wide_sample

	// ==========================================================
	// Registers and state
	ctrl_s ctrl_q;
	codes_s codes_q;
	logic [31:0] crop_start_q, crop_size_q;
	logic [EV_W-1:0] ev_raw_q, ev_en_q, ev_set;
	pins_s pin_meta_q, pin_sync_q;
	logic pclk_prev_q, vs_prev_q, line_prev_q, emb_line_q;
	logic [23:0] hist_q;
	logic [1:0] skip_q, rate_cnt_q, lane_q;
	logic [13:0] x_q, y_q;
	logic [31:0] pack_q;
	cap_state_e cap_q;
	logic [31:0] fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
	logic aw_hold_q, w_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// ==========================================================
	// Pin synchronisers: every pin, the pixel clock included, sees two flops
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			pclk_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= '{data: pixel_data_in, line: line_sync_in, frame: frame_sync_in,
				clk: pixel_clock_in};
			pin_sync_q <= pin_meta_q;
			pclk_prev_q <= pin_sync_q.clk;
		end
	end

	// Edge pick; data travels beside the clock so it is stable at the chosen edge
	logic rise, fall, tick;
	assign rise = pin_sync_q.clk & ~pclk_prev_q;
	assign fall = ~pin_sync_q.clk & pclk_prev_q;
	assign tick = ctrl_q.pedge ? rise : fall;

	// ==========================================================
	// Sync decoding
	logic emb_mode, crop_on, vs_ok, line_ok, is_code, code_known;
	logic fstart, fend, lend, px_ok;
	logic [13:0] px_data;
	logic [7:0] cur_byte;
	assign emb_mode = ctrl_q.esync && ctrl_q.width == WIDTH_8 && !ctrl_q.jpeg;
	assign crop_on = ctrl_q.crop && !ctrl_q.jpeg;
	assign vs_ok = pin_sync_q.frame == ctrl_q.vpol;
	assign line_ok = ctrl_q.jpeg ? ~pin_sync_q.line : (pin_sync_q.line == ctrl_q.hpol);
	assign cur_byte = pin_sync_q.data[7:0];
	assign is_code = hist_q == {SYNC_FF, SYNC_ZERO, SYNC_ZERO};
	assign code_known = cur_byte == codes_q.fs || cur_byte == codes_q.fe
		|| cur_byte == codes_q.ls || cur_byte == codes_q.le;

	// Frame and line markers, one cycle long on a sampling tick
	always_comb begin
		if (emb_mode) begin
			fstart = tick && is_code && cur_byte == codes_q.fs;
			fend = tick && is_code && cur_byte == codes_q.fe;
			lend = tick && is_code && cur_byte == codes_q.le;
			px_ok = tick && emb_line_q && skip_q == 2'h0 && !is_code;
			px_data = {6'h00, hist_q[23:16]};
		end else begin
			fstart = tick && vs_ok && !vs_prev_q;
			fend = tick && !vs_ok && vs_prev_q;
			lend = tick && !line_ok && line_prev_q;
			px_ok = tick && line_ok && vs_ok;
			px_data = pin_sync_q.data;
		end
	end

	// Embedded stream history; output is delayed three bytes so preambles can be dropped
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hist_q <= '0;
			skip_q <= 2'h0;
			emb_line_q <= 1'b0;
			vs_prev_q <= 1'b0;
			line_prev_q <= 1'b0;
		end else if (tick) begin
			vs_prev_q <= vs_ok;
			line_prev_q <= line_ok;
			hist_q <= {hist_q[15:0], cur_byte};
			if (is_code) begin
				skip_q <= CODE_TAIL;
			end else if (skip_q != 2'h0) begin
				skip_q <= skip_q - 2'h1;
			end
			if (is_code && cur_byte == codes_q.ls) begin
				emb_line_q <= 1'b1;
			end else if (is_code && (cur_byte == codes_q.le || cur_byte == codes_q.fe)) begin
				emb_line_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Crop window: counts accepted samples per line and lines per frame
	logic in_win, take, err;
	logic [14:0] x_end, y_end;
	assign x_end = {1'b0, crop_start_q[13:0]} + {1'b0, crop_size_q[13:0]};
	assign y_end = {2'b00, crop_start_q[28:16]} + {1'b0, crop_size_q[29:16]};
	assign in_win = !crop_on || (x_q >= crop_start_q[13:0] && {1'b0, x_q} <= x_end
		&& y_q >= {1'b0, crop_start_q[28:16]} && {1'b0, y_q} <= y_end);
	assign take = cap_q == CAP_ACTIVE && px_ok && in_win;
	assign err = emb_mode && tick && is_code && !code_known && cap_q != CAP_IDLE;

	always_ff @(posedge ref_clk) begin
		if (rst || fstart) begin
			x_q <= '0;
			y_q <= '0;
		end else if (lend) begin
			x_q <= '0;
			y_q <= y_q + 14'h1;
		end else if (px_ok) begin
			x_q <= x_q + 14'h1;
		end
	end

	// ==========================================================
	// Packing into little-endian words
	logic [31:0] word_next;
	logic word_full, push, overflow, fifo_full, fifo_empty, flush, pop;
	logic [31:0] push_word;
	always_comb begin
		word_next = pack_q;
		if (ctrl_q.width == WIDTH_8) begin
			word_next[lane_q*8 +: 8] = px_data[7:0];
			word_full = lane_q == LANE_LAST8;
		end else begin
			word_next[lane_q[0]*16 +: 16] = wide_sample(px_data, ctrl_q.width);
			word_full = lane_q == LANE_LAST16;
		end
	end
	assign push = (take && word_full) || (cap_q == CAP_ACTIVE && fend && lane_q != 2'h0);
	assign push_word = take ? word_next : pack_q;
	assign fifo_full = (wr_ptr_q - rd_ptr_q) == PTR_W'(FIFO_DEPTH);
	assign fifo_empty = wr_ptr_q == rd_ptr_q;
	assign overflow = push && fifo_full;
	assign flush = overflow || err || !ctrl_q.enable;

	always_ff @(posedge ref_clk) begin
		if (rst || fstart || flush) begin
			pack_q <= '0;
			lane_q <= 2'h0;
		end else if (take && word_full) begin
			pack_q <= '0;
			lane_q <= 2'h0;
		end else if (take) begin
			pack_q <= word_next;
			lane_q <= lane_q + 2'h1;
		end else if (fend) begin
			pack_q <= '0;
			lane_q <= 2'h0;
		end
	end

	// ==========================================================
	// Capture sequencing with frame-rate decimation
	logic [1:0] rate_top;
	assign rate_top = (ctrl_q.rate == RATE_HALF || ctrl_q.rate == RATE_THIRD) && !ctrl_q.snapshot
		? ctrl_q.rate : 2'h0;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cap_q <= CAP_IDLE;
			rate_cnt_q <= 2'h0;
		end else if (!ctrl_q.enable) begin
			cap_q <= CAP_IDLE;
			rate_cnt_q <= 2'h0;
		end else if (flush) begin
			cap_q <= CAP_WAIT;
		end else begin
			unique case (cap_q)
				CAP_IDLE: begin
					rate_cnt_q <= 2'h0;
					if (ctrl_q.capture_enable_bit) begin
						cap_q <= CAP_WAIT;
					end
				end
				CAP_WAIT: begin
					if (!ctrl_q.capture_enable_bit) begin
						cap_q <= CAP_IDLE;
					end else if (fstart) begin
						cap_q <= rate_cnt_q == 2'h0 ? CAP_ACTIVE : CAP_SKIP;
						rate_cnt_q <= rate_cnt_q == rate_top ? 2'h0 : rate_cnt_q + 2'h1;
					end
				end
				CAP_SKIP: begin
					if (fend) begin
						cap_q <= CAP_WAIT;
					end
				end
				CAP_ACTIVE: begin
					if (fend) begin
						cap_q <= (ctrl_q.capture_enable_bit && !ctrl_q.snapshot) ? CAP_WAIT : CAP_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Four-word FIFO; the pixel side never stalls, so a full FIFO is overrun
	always_ff @(posedge ref_clk) begin
		if (rst || flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				fifo_mem[wr_ptr_q[PTR_W-2:0]] <= push_word;
				wr_ptr_q <= wr_ptr_q + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + PTR_W'(1);
			end
		end
	end

	// Request line held while a whole word waits; words already live on ref_clk
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dma_req <= 1'b0;
		end else begin
			dma_req <= !fifo_empty && !pop && !flush;
		end
	end

	// ==========================================================
	// Events: hardware set beats a same-cycle software clear
	assign ev_set[EV_LINE] = lend && cap_q == CAP_ACTIVE;
	assign ev_set[EV_FRAME] = fend && cap_q == CAP_ACTIVE && !overflow;
	assign ev_set[EV_OVR] = overflow;
	assign ev_set[EV_VSYNC] = fend;
	assign ev_set[EV_ERR] = err;

	logic wr_go, rd_go;
	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign pop = rd_go && s_axi_araddr == OFS_DATA && !fifo_empty;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ev_raw_q <= '0;
			global_capture_irq <= 1'b0;
		end else begin
			if (wr_go && awaddr_q == OFS_EV_CLR) begin
				ev_raw_q <= (ev_raw_q & ~wdata_q[EV_W-1:0]) | ev_set;
			end else begin
				ev_raw_q <= ev_raw_q | ev_set;
			end
			global_capture_irq <= |(ev_raw_q & ev_en_q);
		end
	end

	// ==========================================================
	// Software registers; snapshot end without overrun clears the capture enable bit unless a register write lands in that cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q <= ctrl_s'(REG_RESET);
			codes_q <= codes_s'(REG_RESET);
			crop_start_q <= REG_RESET;
			crop_size_q <= REG_RESET;
			ev_en_q <= '0;
		end else begin
			if (wr_go) begin
				unique case (awaddr_q)
					OFS_CTRL: ctrl_q <= ctrl_s'(merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK);
					OFS_EV_EN: ev_en_q <= EV_W'(merge({{(DATA_W - EV_W){1'b0}}, ev_en_q},
						wdata_q, wstrb_q));
					OFS_CODES: codes_q <= codes_s'(merge(codes_q, wdata_q, wstrb_q));
					OFS_CROP_START: crop_start_q <= merge(crop_start_q, wdata_q, wstrb_q)
						& CROP_START_MASK;
					OFS_CROP_SIZE: crop_size_q <= merge(crop_size_q, wdata_q, wstrb_q)
						& CROP_SIZE_MASK;
					default: ;
				endcase
			end else if (cap_q == CAP_ACTIVE && fend && ctrl_q.snapshot && !overflow) begin
				ctrl_q.capture_enable_bit <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write: address and data taken in either order, then one response
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_EV_EN
					|| awaddr_q == OFS_EV_CLR || awaddr_q == OFS_CODES
					|| awaddr_q == OFS_CROP_START || awaddr_q == OFS_CROP_SIZE)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read: data register read pops one word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					OFS_CTRL: s_axi_rdata <= ctrl_q;
					OFS_STATE: s_axi_rdata <= {29'h0, !fifo_empty, pin_sync_q.frame,
						pin_sync_q.line};
					OFS_RAW_EV: s_axi_rdata <= {27'h0, ev_raw_q};
					OFS_EV_EN: s_axi_rdata <= {27'h0, ev_en_q};
					OFS_MASKED_EV: s_axi_rdata <= {27'h0, ev_raw_q & ev_en_q};
					OFS_CODES: s_axi_rdata <= codes_q;
					OFS_CROP_START: s_axi_rdata <= crop_start_q;
					OFS_CROP_SIZE: s_axi_rdata <= crop_size_q;
					OFS_DATA: s_axi_rdata <= fifo_empty ? '0 : fifo_mem[rd_ptr_q[PTR_W-2:0]];
					OFS_EV_CLR: s_axi_rdata <= '0;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : camera_receiver
`default_nettype wire

// [camera_receiver_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus handshake and output checks
module camera_receiver_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [camera_receiver_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [camera_receiver_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dma_req,
	input wire logic global_capture_irq
);
	import camera_receiver_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Both write halves taken in one edge, as the bench offers them
	wire logic wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic rtake = s_axi_arvalid && s_axi_arready;
	// ====
	// Assertions
	// Ready drops at the take; the answer follows one cycle after that
	write_answer_a: assert property (wtake |=> !s_axi_awready && !s_axi_wready
		##1 s_axi_bvalid) else $error("write answer late");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped");
	write_reopen_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready) else $error("write channel not reopened");
	read_answer_a: assert property (rtake |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data not held");
	read_reopen_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
		&& s_axi_arready) else $error("read channel not reopened");
	gap_read_err_a: assert property (rtake && s_axi_araddr == 8'h1c |=> s_axi_rresp
		== RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
	ro_write_err_a: assert property (wtake && s_axi_awaddr == OFS_STATE |-> ##2 s_axi_bresp
		== RESP_SLVERR) else $error("read-only write accepted");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid
		&& !dma_req && !global_capture_irq) else $error("outputs busy after reset");
	// A data read takes the waiting word, so the request must drop at once
	data_pop_a: assert property (rtake && s_axi_araddr == OFS_DATA |=> !dma_req)
		else $error("request kept after data read");
	// Main scenarios reached
	c_write: cover property (wtake);
	c_word: cover property ($rose(dma_req));
	c_irq: cover property ($rose(global_capture_irq));
endmodule : camera_receiver_asserts

bind camera_receiver camera_receiver_asserts u_asserts (.ref_clk, .rst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_req, .global_capture_irq);
`default_nettype wire

// [sensor_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Image sensor: clock runs within frames and for one period after, data moves on the idle edge
module sensor_model (
	input wire logic pedge,
	input wire logic line_act,
	output logic pixel_clock_in,
	output logic [13:0] pixel_data_in,
	output logic line_sync_in,
	output logic frame_sync_in
);
	// Quiet pins before the first frame
	initial begin
		pixel_clock_in = 1'b0;
		pixel_data_in = 14'h0;
		line_sync_in = 1'b0;
		frame_sync_in = 1'b0;
	end

	// One pixel period, sampling edge first
	task automatic tick();
		#62.5 pixel_clock_in = pedge;
		#62.5 pixel_clock_in = ~pedge;
	endtask : tick

	// One frame of nl lines; data inverted in the gaps between lines
	task automatic frame(input int nl, input logic [13:0] px[$]);
		int np;
		np = px.size() / nl;
		#1;
		frame_sync_in = 1'b1;
		line_sync_in = ~line_act;
		pixel_clock_in = ~pedge;
		tick();
		for (int l = 0; l < nl; l++) begin
			for (int i = 0; i < np; i++) begin
				pixel_data_in = px[l * np + i];
				line_sync_in = line_act;
				tick();
			end
			line_sync_in = ~line_act;
			pixel_data_in = ~pixel_data_in;
			repeat (2) tick();
		end
		frame_sync_in = 1'b0;
		pixel_data_in = ~pixel_data_in;
		tick();
		#500;
	endtask : frame
endmodule : sensor_model
`default_nettype wire

// [parallel_camera_capture_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench: sensor frames in, words read back through the data register
module parallel_camera_capture_test;
	import camera_receiver_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, pedge = 1'b1, line_act = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic pixel_clock_in, line_sync_in, frame_sync_in, dma_req, global_capture_irq;
	logic [13:0] pixel_data_in;
	logic [31:0] exp_q[$];
	int err_total = 0;
	int tests_run = 0;

	camera_receiver u_camera_receiver (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pixel_clock_in, .pixel_data_in, .line_sync_in, .frame_sync_in, .dma_req,
		.global_capture_irq);
	sensor_model u_sensor_model (.pedge, .line_act, .pixel_clock_in, .pixel_data_in,
		.line_sync_in, .frame_sync_in);

	// 100 MHz system clock
	always #5 ref_clk = ~ref_clk;

	// ====
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// Each channel is released only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge ref_clk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Expected words: little-endian lanes, zero upper bits, zero-padded tail
	function automatic void pack(input logic [13:0] px[$], input logic [1:0] w);
		logic [31:0] word;
		int k;
		word = '0;
		k = 0;
		foreach (px[i]) begin
			if (w == WIDTH_8) word[8*k +: 8] = px[i][7:0];
			else word[16*k +: 16] = 16'(px[i] & (14'h3fff >> (6 - 2 * w)));
			k++;
			if (k == ((w == WIDTH_8) ? 4 : 2)) begin
				exp_q.push_back(word);
				word = '0;
				k = 0;
			end
		end
		if (k != 0) exp_q.push_back(word);
	endfunction : pack

	// Send nfr equal frames, expect keep of them, drain while they stream
	task automatic run(input logic [31:0] c, input int nl, input int nfr, input int keep,
		input bit stop);
		logic [13:0] px[$], win[$];
		logic [31:0] d;
		logic [1:0] r;
		bit done;
		int np;
		repeat (nl * (4 + $urandom % 4)) px.push_back(14'($urandom));
		np = px.size() / nl;
		win = px;
		// Crop window set by the bench: line 1, samples 1 to 4 of that line
		if (c[2] && !c[3]) begin
			win = {};
			foreach (px[i]) if ((i / np == 1) && ((i % np) inside {[1:4]})) win.push_back(px[i]);
		end
		// Embedded framing on one line; data bytes stay below 127, so none is 0xff and no preamble forms
		if (c[4] && !c[3]) begin
			win = {};
			repeat (8) win.push_back(14'($urandom % 127));
			px = {14'h0ff, 14'h0, 14'h0, 14'hab, 14'h0ff, 14'h0, 14'h0, 14'h80, win,
				14'h0ff, 14'h0, 14'h0, 14'h9d, 14'h0ff, 14'h0, 14'h0, 14'hb6};
		end
		exp_q = {};
		repeat (keep) pack(win, c[11:10]);
		pedge <= c[5];
		line_act <= ~c[3];
		wr(OFS_CTRL, c & ~32'h1, r);
		wr(OFS_CTRL, c, r);
		done = 1'b0;
		fork
			begin
				repeat (nfr) u_sensor_model.frame(nl, px);
				done = 1'b1;
			end
			begin
				if (stop) begin
					repeat (60) @(posedge ref_clk);
					wr(OFS_CTRL, c & ~32'h1, r);
				end
				while (!done || dma_req === 1'b1) begin
					if (dma_req === 1'b1) begin
						rd(OFS_DATA, d, r);
						check(d, exp_q.pop_front());
						repeat (2) @(posedge ref_clk);
					end else begin
						@(posedge ref_clk);
					end
				end
			end
		join
		check(32'(exp_q.size()), 32'h0);
	endtask : run

	// ====
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [13:0] big[$];
		void'($urandom(32'h62e3));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFS_CTRL, d, r);
		check(d, REG_RESET);
		rd(8'h1c, d, r);
		check(32'(r), 32'(RESP_SLVERR));
		wr(OFS_STATE, 32'h1, r);
		check(32'(r), 32'(RESP_SLVERR));
		// Every width, both pixel edges, two frames back to back
		for (int w = 0; w < 4; w++) run(32'h40c1 | w << 10 | (w & 1) << 5, 3, 2, 2, 0);
		// Decimation: one frame kept of two, then of three; then capture stopped during the first of two frames
		for (int k = 1; k < 3; k++) run(32'h40e1 | k << 8, 2, k + 1, 1, 0);
		run(32'h40e1, 3, 2, 1, 1);
		// Window of one line and four samples, then codes framing one line
		wr(OFS_CROP_START, 32'h0001_0001, r);
		wr(OFS_CROP_SIZE, 32'h0000_0003, r);
		run(32'h40e5, 3, 1, 1, 0);
		wr(OFS_CODES, 32'hb69d_80ab, r);
		run(32'h40f1, 1, 1, 1, 0);
		// Compressed stream ignores crop and embedded codes
		run(32'h40fd, 3, 1, 1, 0);
		// Overrun: a frame nobody drains
		repeat (40) big.push_back(14'($urandom));
		line_act <= 1'b1;
		wr(OFS_CTRL, 32'h40e1, r);
		u_sensor_model.frame(2, big);
		rd(OFS_RAW_EV, d, r);
		check(32'(d[EV_OVR]), 32'h1);
		// Snapshot then events and the global interrupt
		wr(OFS_EV_CLR, 32'h1f, r);
		run(32'h40e3, 2, 2, 1, 0);
		rd(OFS_CTRL, d, r);
		check(32'(d[0]), 32'h0);
		rd(OFS_RAW_EV, d, r);
		check(d, 32'h0b);
		wr(OFS_EV_EN, 32'h04, r);
		repeat (3) @(posedge ref_clk);
		check(32'(global_capture_irq), 32'h0);
		wr(OFS_EV_EN, 32'h1f, r);
		repeat (3) @(posedge ref_clk);
		check(32'(global_capture_irq), 32'h1);
		wr(OFS_EV_CLR, 32'h1f, r);
		repeat (3) @(posedge ref_clk);
		check(32'(global_capture_irq), 32'h0);
		conclude();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#600000;
		err_total++;
		conclude();
	end
endmodule : parallel_camera_capture_test
`default_nettype wire
